// ==== rtl/bcs_pkg.sv ====
// constants, types and decode helpers for the converter clock and soft-start control
// Notes on behaviour
// - oscillator runs at 4, 7 or 10 MHz
// - frequency latched at each enable, strap changes ignored afterwards
// - external sync clock replaces the internal oscillator
// - sync accepted only within ten percent of nominal
// - internal oscillator used before and after sync
// - synced switching cycles start on sync rising edge
// - first sync rise enters sync mode, starts locking
// - sync lost after four internal cycles, fall back
// - soft start ramps reference from zero to nominal
// - soft start: power good low, loop idle, window faults off, overcurrent still trips hiccup
// - after soft start, run and release power good
// - soft-start selection latched at enable from off, reset loads the 64 us default
// - 4 MHz: 64, 512 or 4096 us soft start
// - 7 MHz: 36.6 or 293 us soft start
// - 10 MHz: 25.6, 205 or 1638 us soft start
// - power good low outside 95 to 105 percent
// - two current-limit levels from the limit strap
// - hiccup waits a fixed count of oscillator cycles
// - current-limit selection latched until enable cycled
`default_nettype none
package bcs_pkg;
    localparam int unsigned CLK_NS = 100;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_REF = 8'h08;
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_SYNC_BIT = 2;
    localparam int ST_LOCK_BIT = 3;
    localparam int ST_PLL_BIT = 4;
    localparam int ST_PG_BIT = 5;
    localparam int ST_CODE_LSB = 6;
    localparam int ST_LIM_BIT = 9;
    localparam int FB_LO_GOOD = 0;
    localparam int FB_HI_GOOD = 1;
    localparam int FB_UV = 2;
    localparam int FB_OV = 3;
    localparam logic [7:0] REF_NOM = 8'hFF;
    // oscillator emulated OSC_SCALE/10 times slower than real silicon
    localparam int unsigned OSC_SCALE = 80;
    localparam int unsigned F_MHZ_4 = 4;
    localparam int unsigned F_MHZ_7 = 7;
    localparam int unsigned F_MHZ_10 = 10;
    localparam logic [7:0] OSC_PER_4 = 8'(OSC_SCALE / F_MHZ_4);
    localparam logic [7:0] OSC_PER_7 = 8'(OSC_SCALE / F_MHZ_7);
    localparam logic [7:0] OSC_PER_10 = 8'(OSC_SCALE / F_MHZ_10);
    localparam int unsigned SYNC_LOSS_OSC = 4;
    localparam logic [2:0] LOSS_LAST = 3'(SYNC_LOSS_OSC - 1);
    localparam int unsigned HIC_OSC = 131072;
    localparam int unsigned SS0_NS = 64000;
    localparam int unsigned SS1_NS = 512000;
    localparam int unsigned SS2_NS = 4096000;
    localparam int unsigned SS3_NS = 36600;
    localparam int unsigned SS4_NS = 293000;
    localparam int unsigned SS5_NS = 25600;
    localparam int unsigned SS6_NS = 205000;
    localparam int unsigned SS7_NS = 1638000;
    localparam int unsigned SS0_CYC = SS0_NS / CLK_NS;
    localparam int unsigned SS1_CYC = SS1_NS / CLK_NS;
    localparam int unsigned SS2_CYC = SS2_NS / CLK_NS;
    localparam int unsigned SS3_CYC = SS3_NS / CLK_NS;
    localparam int unsigned SS4_CYC = SS4_NS / CLK_NS;
    localparam int unsigned SS5_CYC = SS5_NS / CLK_NS;
    localparam int unsigned SS6_CYC = SS6_NS / CLK_NS;
    localparam int unsigned SS7_CYC = SS7_NS / CLK_NS;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_SOFT = 2'b01,
        ST_RUN = 2'b10,
        ST_HICCUP = 2'b11
    } bcs_state_t;

    typedef enum logic [1:0] {
        FQ_4 = 2'b00,
        FQ_7 = 2'b01,
        FQ_10 = 2'b10
    } bcs_freq_t;

    function automatic bcs_freq_t bcs_freq_of(input logic [2:0] code);
        if (code < 3'h3) begin
            return FQ_4;
        end else if (code < 3'h5) begin
            return FQ_7;
        end
        return FQ_10;
    endfunction

    function automatic logic [7:0] bcs_osc_per_of(input bcs_freq_t f);
        unique case (f)
            FQ_4: return OSC_PER_4;
            FQ_7: return OSC_PER_7;
            FQ_10: return OSC_PER_10;
            default: return OSC_PER_4;
        endcase
    endfunction
endpackage
`default_nettype wire

// ==== rtl/bcs_sync_if.sv ====
// signals between the control core and the sync clock tracker
`default_nettype none
interface bcs_sync_if;
    logic [7:0] per;
    logic tick;
    logic rise;
    logic mode;
    logic locked;
    modport trk (input per, input tick, output rise, output mode, output locked);
    modport ctl (output per, output tick, input rise, input mode, input locked);
endinterface
`default_nettype wire

// ==== rtl/bcs_sync_trk.sv ====
// sync pin tracker: edge detect, period check, loss detect
`default_nettype none
module bcs_sync_trk (
    input wire logic clock, // system clock
    input wire logic rst_n, // synchronous reset
    input wire logic sync_pin, // external sync clock
    bcs_sync_if.trk trk // tracker side
);
    import bcs_pkg::*;

    logic s1_q, s2_q, s3_q;
    logic [9:0] per_cnt_q;
    logic [2:0] loss_cnt_q;
    logic mode_q, locked_q;
    logic rise;
    logic in_rng;
    logic [15:0] meas10;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= sync_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign rise = s2_q & ~s3_q;
    // two clocks of sampling slack on the low side of the window, none on the high side
    assign meas10 = 16'(per_cnt_q) * 16'd10;
    assign in_rng = (meas10 + 16'd20 >= 16'(trk.per) * 16'd9)
        && (meas10 <= 16'(trk.per) * 16'd11);

    always_ff @(posedge clock) begin
        if (!rst_n || rise) begin
            per_cnt_q <= 10'h000;
        end else if (per_cnt_q != 10'h3FF) begin
            per_cnt_q <= per_cnt_q + 10'h001;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || rise) begin
            loss_cnt_q <= 3'h0;
        end else if (trk.tick && loss_cnt_q != LOSS_LAST) begin
            loss_cnt_q <= loss_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode_q <= 1'b0;
            locked_q <= 1'b0;
        end else if (rise) begin
            mode_q <= 1'b1;
            locked_q <= mode_q & in_rng;
        end else if (mode_q && trk.tick && loss_cnt_q == LOSS_LAST) begin
            mode_q <= 1'b0;
            locked_q <= 1'b0;
        end
    end

    assign trk.rise = rise;
    assign trk.mode = mode_q;
    assign trk.locked = locked_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_sync_enter: assert property (rise |=> mode_q)
        else $error("sync rise did not enter sync mode");
    a_sync_loss: assert property (mode_q && trk.tick && loss_cnt_q == LOSS_LAST && !rise
        |=> !mode_q && !locked_q)
        else $error("sync loss did not fall back");
    a_loss_count: assert property (mode_q && !rise && loss_cnt_q == 3'h0
        |-> $past(rise) || $past(loss_cnt_q) == 3'h0)
        else $error("loss counter not cleared by rise");
    c_sync_loss: cover property (mode_q ##1 !mode_q);
endmodule
`default_nettype wire

// ==== rtl/bcs_ctrl.sv ====
// converter clock, strap capture, soft-start and power-good control with APB registers
`default_nettype none
module bcs_ctrl #(
    parameter int unsigned SS1_CYC_P = bcs_pkg::SS1_CYC, // 512 us soft start
    parameter int unsigned SS2_CYC_P = bcs_pkg::SS2_CYC, // 4096 us soft start
    parameter int unsigned SS7_CYC_P = bcs_pkg::SS7_CYC, // 1638 us soft start
    parameter int unsigned HIC_OSC_P = bcs_pkg::HIC_OSC // hiccup oscillator cycles
) (
    input wire logic clock, // system clock, 10 MHz
    input wire logic rst_n, // synchronous reset, power-up
    input wire logic [7:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [2:0] timing_strap_pin, // frequency and soft-start strap code
    input wire logic limit_strap_pin, // current-limit strap
    input wire logic sync_pin, // external sync clock
    input wire logic [3:0] feedback_sense, // window comparators
    input wire logic overcurrent_trip, // overcurrent flag
    output logic power_good_output_o, // open-drain level, always low
    output logic power_good_output_oe_n, // low while pulling down
    output logic cycle_start, // switching cycle start pulse
    output logic phase_b, // phase of the current cycle
    output logic [7:0] ref_level, // reference ramp code
    output logic pll_active, // tracking the sync clock
    output logic limit_sel // latched current-limit choice
);
    import bcs_pkg::*;

    bcs_sync_if sif();

    bcs_sync_trk u_trk (
        .clock(clock),
        .rst_n(rst_n),
        .sync_pin(sync_pin),
        .trk(sif.trk)
    );

    function automatic logic [15:0] ss_len_of(input logic [2:0] code);
        unique case (code)
            3'h0: return 16'(SS0_CYC);
            3'h1: return 16'(SS1_CYC_P);
            3'h2: return 16'(SS2_CYC_P);
            3'h3: return 16'(SS3_CYC);
            3'h4: return 16'(SS4_CYC);
            3'h5: return 16'(SS5_CYC);
            3'h6: return 16'(SS6_CYC);
            3'h7: return 16'(SS7_CYC_P);
        endcase
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return a == REG_CTRL || a == REG_STAT || a == REG_REF;
    endfunction

    logic [8:0] pin_s1_q, pin_s2_q;
    logic [2:0] strap_s;
    logic lim_s, oc_s;
    logic [3:0] fb_s;

    // pins are asynchronous to the system clock
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_s1_q <= 9'h000;
            pin_s2_q <= 9'h000;
        end else begin
            pin_s1_q <= {overcurrent_trip, feedback_sense, limit_strap_pin, timing_strap_pin};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign strap_s = pin_s2_q[2:0];
    assign lim_s = pin_s2_q[3];
    assign fb_s = pin_s2_q[7:4];
    assign oc_s = pin_s2_q[8];

    bcs_state_t state_q;
    logic en_q, en_d1_q, en_rise;
    logic [2:0] code_q;
    logic lim_q;
    logic [7:0] osc_per_q, step_len_q;
    logic [15:0] ss_len_q, ss_len_d, ss_cnt_q;
    logic [7:0] osc_cnt_q, step_cnt_q, ref_q;
    logic [16:0] hic_cnt_q;
    logic osc_tick, sw_on, pll_act, start, win_fault, pg_d;
    logic ss_done, hic_done;
    logic [31:0] stat_word;
    logic pready_q, pslverr_q, cycle_q, phase_q, pll_q, pg_oe_n_q, pg_o_q;
    logic [31:0] prdata_q;

    // apb: two-cycle access phase so every output is registered
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~is_mapped(paddr);
            prdata_q <= 32'h0000_0000;
            if (psel && penable && !pready_q && !pwrite) begin
                unique case (paddr)
                    REG_CTRL: prdata_q <= 32'(en_q) << CTRL_EN_BIT;
                    REG_STAT: prdata_q <= stat_word;
                    REG_REF: prdata_q <= {24'h000000, ref_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            en_q <= 1'b0;
        end else if (psel && penable && pready_q && pwrite && paddr == REG_CTRL) begin
            en_q <= pwdata[CTRL_EN_BIT];
        end
    end

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[ST_STATE_LSB +: 2] = state_q;
        stat_word[ST_SYNC_BIT] = sif.mode;
        stat_word[ST_LOCK_BIT] = sif.locked;
        stat_word[ST_PLL_BIT] = pll_q;
        stat_word[ST_PG_BIT] = pg_oe_n_q;
        stat_word[ST_CODE_LSB +: 3] = code_q;
        stat_word[ST_LIM_BIT] = lim_q;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            en_d1_q <= 1'b0;
        end else begin
            en_d1_q <= en_q;
        end
    end

    assign en_rise = en_q & ~en_d1_q;
    assign ss_len_d = ss_len_of(strap_s);

    // straps are only looked at on the way out of the off state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            code_q <= 3'h0;
            lim_q <= 1'b0;
            osc_per_q <= OSC_PER_4;
            ss_len_q <= 16'(SS0_CYC);
            step_len_q <= 8'h01;
        end else if (state_q == ST_OFF && en_rise) begin
            code_q <= strap_s;
            lim_q <= lim_s;
            osc_per_q <= bcs_osc_per_of(bcs_freq_of(strap_s));
            ss_len_q <= ss_len_d;
            step_len_q <= (ss_len_d[15:8] == 8'h00) ? 8'h01 : ss_len_d[15:8];
        end
    end

    // internal oscillator free-runs; it also times hiccup and sync loss
    assign osc_tick = osc_cnt_q == osc_per_q - 8'h01;

    always_ff @(posedge clock) begin
        if (!rst_n || osc_tick) begin
            osc_cnt_q <= 8'h00;
        end else begin
            osc_cnt_q <= osc_cnt_q + 8'h01;
        end
    end

    assign sif.per = osc_per_q;
    assign sif.tick = osc_tick;

    assign ss_done = ss_cnt_q == ss_len_q - 16'h0001;
    assign hic_done = osc_tick && hic_cnt_q == 17'(HIC_OSC_P - 1);
    assign win_fault = fb_s[FB_UV] | fb_s[FB_OV];

    always_ff @(posedge clock) begin
        if (!rst_n || !en_q) begin
            state_q <= ST_OFF;
        end else begin
            unique case (state_q)
                ST_OFF: if (en_rise) begin
                    state_q <= ST_SOFT;
                end
                ST_SOFT: if (oc_s) begin
                    state_q <= ST_HICCUP;
                end else if (ss_done) begin
                    state_q <= ST_RUN;
                end
                ST_RUN: if (oc_s || win_fault) begin
                    state_q <= ST_HICCUP;
                end
                ST_HICCUP: if (hic_done) begin
                    state_q <= ST_SOFT;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || state_q != ST_SOFT) begin
            ss_cnt_q <= 16'h0000;
        end else begin
            ss_cnt_q <= ss_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || state_q != ST_HICCUP) begin
            hic_cnt_q <= 17'h00000;
        end else if (osc_tick) begin
            hic_cnt_q <= hic_cnt_q + 17'h00001;
        end
    end

    // ramp reaches full scale near the end of the interval, then waits
    always_ff @(posedge clock) begin
        if (!rst_n || state_q == ST_OFF || state_q == ST_HICCUP) begin
            ref_q <= 8'h00;
            step_cnt_q <= 8'h00;
        end else if (state_q == ST_RUN) begin
            ref_q <= REF_NOM;
        end else if (step_cnt_q == step_len_q - 8'h01) begin
            step_cnt_q <= 8'h00;
            ref_q <= (ref_q == REF_NOM) ? ref_q : ref_q + 8'h01;
        end else begin
            step_cnt_q <= step_cnt_q + 8'h01;
        end
    end

    assign sw_on = state_q == ST_SOFT || state_q == ST_RUN;
    // a sync clock outside the window is not followed
    assign pll_act = sif.mode & sif.locked & (state_q == ST_RUN);
    assign start = sw_on & (pll_act ? sif.rise : osc_tick);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cycle_q <= 1'b0;
            phase_q <= 1'b0;
            pll_q <= 1'b0;
        end else begin
            cycle_q <= start;
            pll_q <= pll_act;
            if (!sw_on) begin
                phase_q <= 1'b0;
            end else if (start) begin
                phase_q <= ~phase_q; // each phase at half rate
            end
        end
    end

    assign pg_d = state_q == ST_RUN && !oc_s && !win_fault
        && !fb_s[FB_LO_GOOD] && !fb_s[FB_HI_GOOD];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pg_oe_n_q <= 1'b0;
            pg_o_q <= 1'b0;
        end else begin
            pg_oe_n_q <= pg_d;
            pg_o_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign power_good_output_o = pg_o_q;
    assign power_good_output_oe_n = pg_oe_n_q;
    assign cycle_start = cycle_q;
    assign phase_b = phase_q;
    assign ref_level = ref_q;
    assign pll_active = pll_q;
    assign limit_sel = lim_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_strap_hold: assert property (state_q != ST_OFF && $past(state_q) != ST_OFF
        |-> $stable(code_q) && $stable(lim_q))
        else $error("strap selection changed while running");
    a_pg_soft_low: assert property (state_q == ST_SOFT |=> !power_good_output_oe_n)
        else $error("power good released during soft start");
    a_pll_soft_idle: assert property (state_q == ST_SOFT |=> !pll_active)
        else $error("loop active during soft start");
    a_sync_start: assert property (pll_act && sif.rise |=> cycle_start)
        else $error("synced cycle did not start on sync rise");
    a_int_start: assert property (sw_on && !pll_act && osc_tick |=> cycle_start)
        else $error("internal cycle start missing");
    a_ss_end_run: assert property (state_q == ST_SOFT && ss_done && !oc_s && en_q
        |=> state_q == ST_RUN ##1 ref_level == REF_NOM)
        else $error("soft start did not end in run");
    a_ref_from_zero: assert property ($rose(state_q == ST_SOFT) |-> ref_level == 8'h00)
        else $error("ramp did not start from zero");
    a_pg_window: assert property (state_q == ST_RUN && fb_s[FB_LO_GOOD]
        |=> !power_good_output_oe_n)
        else $error("power good released outside window");
    a_hiccup_end: assert property (state_q == ST_HICCUP && hic_done && en_q
        |=> state_q == ST_SOFT)
        else $error("hiccup did not restart soft start");
    a_limit_out: assert property (state_q == ST_OFF && en_rise
        |=> limit_sel == $past(lim_s) && code_q == $past(strap_s))
        else $error("strap selection not captured at enable");

    c_soft_to_run: cover property (state_q == ST_SOFT ##1 state_q == ST_RUN);
    c_hiccup: cover property (state_q == ST_RUN ##1 state_q == ST_HICCUP);
    c_pll_run: cover property (pll_active && cycle_start);
    c_pg_good: cover property ($rose(power_good_output_oe_n));
endmodule
`default_nettype wire

// ==== bench/bcs_sync_src.sv ====
// board master clock model driving the sync input
`default_nettype none
module bcs_sync_src (
    input wire logic run, // clock runs while high
    input wire logic [15:0] half_ns, // half period in ns
    output logic sync_pin // square wave to the block
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sync_pin = 1'b0;
        #37;
        forever begin
            if (run) begin
                sync_pin = 1'b1; // equal halves, 50 percent duty
                #(half_ns); // out of range only when the bench asks
                sync_pin = 1'b0;
                #(half_ns);
            end else begin
                #50; // stopped source rests low, no edges
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/bcs_ctrl_tb.sv ====
// self-checking bench for the clock and soft-start control block
`default_nettype none
module bcs_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bcs_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, sync_pin, pg_o, pg_oe_n, cycle_start, phase_b, pll_active, limit_sel;
    logic [2:0] timing_strap_pin = 3'h0;
    logic limit_strap_pin = 1'b0;
    logic [3:0] feedback_sense = 4'h0;
    logic overcurrent_trip = 1'b0;
    logic [7:0] ref_level;
    logic sync_run = 1'b0;
    logic [15:0] sync_half = 16'd400;
    int err_total = 0;
    int n_compared = 0;
    int n;
    int ss_tab [8] = '{640, 600, 1000, 366, 2930, 256, 2050, 800};

    bcs_ctrl #(.SS1_CYC_P(600), .SS2_CYC_P(1000), .SS7_CYC_P(800), .HIC_OSC_P(16)) i_bcs_ctrl (
        .clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timing_strap_pin(timing_strap_pin), .limit_strap_pin(limit_strap_pin),
        .sync_pin(sync_pin), .feedback_sense(feedback_sense),
        .overcurrent_trip(overcurrent_trip), .power_good_output_o(pg_o),
        .power_good_output_oe_n(pg_oe_n), .cycle_start(cycle_start), .phase_b(phase_b),
        .ref_level(ref_level), .pll_active(pll_active), .limit_sel(limit_sel));
    bcs_sync_src i_bcs_sync_src (.run(sync_run), .half_ns(sync_half), .sync_pin(sync_pin));

    initial begin
        forever #50 clock = ~clock;
    end

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            err_total++;
            report_and_stop();
        end
        rd = prdata;
        chk("pslverr", 32'(e), 32'(pslverr));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // cycles between two switching starts, phase must alternate
    task automatic per_chk(input int exp);
        int k;
        logic p;
        k = 0;
        while (cycle_start !== 1'b1 && k < 100) begin
            @(posedge clock);
            k++;
        end
        p = phase_b;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (cycle_start !== 1'b1 && k < 100);
        chk("cycle period", 32'(exp), 32'(k));
        chk("phase", 32'(!p), 32'(phase_b));
    endtask

    task automatic start_run(input int ss);
        logic [7:0] prev;
        apb(1'b1, REG_CTRL, 32'h1, 1'b0);
        timing_strap_pin <= ~timing_strap_pin;
        limit_strap_pin <= ~limit_strap_pin;
        prev = 8'h00;
        n = 0;
        while (pg_oe_n !== 1'b1 && n < 5000) begin
            @(posedge clock);
            n++;
            chk("ramp rising", 1, 32'(ref_level >= prev));
            chk("loop idle", 0, 32'(pll_active));
            prev = ref_level;
        end
        chk("soft length ok", 1, 32'(n >= ss - 2 && n <= ss + 6));
        chk("ref level", 32'(REF_NOM), 32'(ref_level));
    endtask

    initial begin
        #9000000;
        err_total++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk("pg after reset", 0, 32'(pg_oe_n));
        apb(1'b0, REG_STAT, 32'h0, 1'b0);
        chk("stat reset", 0, rd);
        apb(1'b0, 8'h0C, 32'h0, 1'b1);
        chk("unmapped read", 0, rd);
        for (int c = 0; c < 8; c++) begin
            timing_strap_pin <= 3'(c);
            limit_strap_pin <= c[0];
            repeat (3) @(posedge clock);
            start_run(ss_tab[c]);
            per_chk(c < 3 ? OSC_PER_4 : (c < 5 ? OSC_PER_7 : OSC_PER_10));
            apb(1'b0, REG_STAT, 32'h0, 1'b0);
            chk("state run", 2, 32'(rd[1:0]));
            chk("held code", 32'(c), 32'(rd[8:6]));
            chk("held limit", 32'(c[0]), 32'(rd[9]));
            chk("limit_sel", 32'(c[0]), 32'(limit_sel));
            apb(1'b1, REG_CTRL, 32'h0, 1'b0);
        end
        timing_strap_pin <= 3'h5;
        repeat (3) @(posedge clock);
        start_run(256);
        for (int b = 0; b < 2; b++) begin
            feedback_sense <= 4'(1 << b);
            repeat (6) @(posedge clock);
            chk("pg outside window", 0, 32'(pg_oe_n));
            feedback_sense <= 4'h0;
            repeat (6) @(posedge clock);
            chk("pg inside window", 1, 32'(pg_oe_n));
            chk("pg pin level", 0, 32'(pg_o));
        end
        sync_half <= 16'd600;
        sync_run <= 1'b1;
        repeat (80) @(posedge clock);
        chk("no lock off rate", 0, 32'(pll_active));
        sync_half <= 16'd400;
        repeat (80) @(posedge clock);
        chk("locked", 1, 32'(pll_active));
        n = 0;
        while (sync_pin !== 1'b0 && n < 100) begin
            #10;
            n++;
        end
        while (sync_pin !== 1'b1 && n < 200) begin
            #10;
            n++;
        end
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (cycle_start !== 1'b1 && n < 20);
        chk("start on sync rise", 1, 32'(n >= 3 && n <= 6));
        per_chk(8);
        sync_run <= 1'b0;
        n = 0;
        while (pll_active !== 1'b0 && n < 100) begin
            @(posedge clock);
            n++;
        end
        chk("loss delay ok", 1, 32'(n >= 20 && n <= 48));
        apb(1'b0, REG_STAT, 32'h0, 1'b0);
        chk("sync mode off", 0, 32'(rd[ST_SYNC_BIT]));
        per_chk(8);
        feedback_sense <= 4'h4;
        repeat (6) @(posedge clock);
        apb(1'b0, REG_STAT, 32'h0, 1'b0);
        chk("hiccup state", 3, 32'(rd[1:0]));
        chk("pg in fault", 0, 32'(pg_oe_n));
        feedback_sense <= 4'h0;
        n = 0;
        while (pg_oe_n !== 1'b1 && n < 2000) begin
            @(posedge clock);
            n++;
        end
        chk("restart delay ok", 1, 32'(n >= 340 && n <= 420));
        apb(1'b0, REG_REF, 32'h0, 1'b0);
        chk("ref reg", 32'(REF_NOM), rd);
        overcurrent_trip <= 1'b1;
        repeat (6) @(posedge clock);
        apb(1'b0, REG_STAT, 32'h0, 1'b0);
        chk("overcurrent hiccup", 3, 32'(rd[1:0]));
        chk("pg in overcurrent", 0, 32'(pg_oe_n));
        overcurrent_trip <= 1'b0;
        report_and_stop();
    end
endmodule
`default_nettype wire
